// ===== hdl/lgc_pkg.sv
/*
  Constants for the global line control and violation-counter select block.
  Assumes one 100 MHz register clock shared by every user of this package.
*/
package lgc_pkg;
  localparam int NUM_CHAN = 8;
  localparam int COUNT_W = 16;
  // Host register offsets
  localparam logic [7:0] TX_TERM_SRC_OFFSET = 8'h82;
  localparam logic [7:0] CHAN_SELECT_OFFSET = 8'h8c;
  localparam logic [7:0] COUNT_CTRL_OFFSET = 8'h8d;
  localparam logic [7:0] COUNT_READ_OFFSET = 8'h8e;
  // Reset values
  localparam logic [7:0] TX_TERM_SRC_RESET = 8'h00;
  localparam logic [7:0] CHAN_SELECT_RESET = 8'h00;
  localparam logic [7:0] COUNT_CTRL_RESET = 8'h00;
  // Field positions
  localparam int TX_ENABLE_SOURCE_SEL_BIT = 7;
  localparam int RX_TERMINATION_SOURCE_SEL_BIT = 6;
  localparam int ALL_COUNT_CLEAR_BIT = 4;
  localparam int ALL_COUNT_LATCH_BIT = 3;
  localparam int COUNTER_BYTE_CHOICE_BIT = 2;
  localparam int PER_CHANNEL_COUNT_LATCH_BIT = 1;
  localparam int PER_CHANNEL_COUNT_CLEAR_BIT = 0;
  // Channel code: value minus one is the channel
  localparam logic [3:0] CHAN_CODE_NONE = 4'h0;
  localparam logic [3:0] CHAN_CODE_FIRST = 4'h1;
  localparam logic [3:0] CHAN_CODE_LAST = 4'h8;
  // Clear must be held this long before the counter is zeroed
  localparam int CLK_PERIOD_NS = 10;
  localparam int CLEAR_HOLD_NS = 1000;
  localparam int CLEAR_HOLD_CYCLES = (CLEAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 7;
  localparam logic [HOLD_W-1:0] CLEAR_HOLD_COUNT = HOLD_W'(CLEAR_HOLD_CYCLES);
  localparam logic [COUNT_W-1:0] COUNT_MAX = 16'hffff;
endpackage : lgc_pkg

// ===== hdl/lgc_chan_if.sv
/*
  Carrier between the control block and one channel's violation counter.
  Assumes both ends run on the same register clock.
*/
`timescale 1ns/1ps
interface lgc_chan_if;
  import lgc_pkg::*;
  logic bump;
  logic latch;
  logic clear;
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] held;
  modport ctrl (output bump, output latch, output clear, input count, input held);
  modport counter (input bump, input latch, input clear, output count, output held);
endinterface : lgc_chan_if

// ===== hdl/lgc_counter.sv
/*
  One channel's sixteen-bit line code violation counter and holding register.
  Assumes bump is one cycle per violation and clear is a level.
*/
`timescale 1ns/1ps
module lgc_counter
  import lgc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  lgc_chan_if.counter chan
);
  logic [COUNT_W-1:0] count;
  logic [COUNT_W-1:0] held;
  logic [COUNT_W-1:0] next_count;

  // Saturate rather than wrap so a busy line never reads as quiet
  assign next_count = chan.clear ? '0 :
                      (chan.bump && count != COUNT_MAX) ? count + 16'h0001 : count;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      count <= '0;
      held <= '0;
    end else begin
      count <= next_count;
      if (chan.latch) begin
        held <= count;
      end
    end
  end

  assign chan.count = count;
  assign chan.held = held;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  held_copy_a: assert property (chan.latch |=> held == $past(count))
    else $error("Holding register missed the latched count");
  clear_zero_a: assert property (chan.clear [*2] |-> count == 16'h0000)
    else $error("Counter not zero while clear is held");
endmodule : lgc_counter

// ===== hdl/lgc_global_ctrl.sv
/*
  Global transmit/termination source control and violation counter select,
  with the counter control and readback registers they steer.
  Assumes a host bus with synchronous active-low strobes on MCLK.
*/
// What this block does
// - Bit 7 of the source register picks channel register bits (0) or pins (1) for transmit enables.
// - Bit 6 picks per-channel register bits (0) or the one global pin (1) for receive termination.
// - Bits 5 to 0 of the source register are plain storage that resets to zero.
// - The low nibble of the select register picks whose counter byte the readback returns.
// - The same nibble picks which counter a per-channel latch or clear acts on.
// - Code 0 selects no channel and codes 1 to 8 select channels 0 to 7.
// - The upper nibble of the select register is plain storage that resets to zero.
// - After reset the readback shows the low byte with no channel selected.
// - The byte choice bit returns the low byte at 0 and the high byte at 1.
// - Setting the per-channel latch copies the live count into the holding register that is read.
`timescale 1ns/1ps
module lgc_global_ctrl
  import lgc_pkg::*;
(
  input wire logic MCLK,
  input wire logic RSTN,
  input wire logic CS_N,
  input wire logic WR_N,
  input wire logic RD_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  output logic [7:0] RDATA,
  input wire logic [NUM_CHAN-1:0] TX_ENABLE_REG,
  input wire logic [NUM_CHAN-1:0] TX_ENABLE_PIN,
  input wire logic [NUM_CHAN-1:0] RX_TERM_REG,
  input wire logic RX_TERM_PIN,
  input wire logic [NUM_CHAN-1:0] VIOLATION_PULSE,
  output logic [NUM_CHAN-1:0] TRANSMITTER_OUTPUT_ENABLE,
  output logic [NUM_CHAN-1:0] RX_TERMINATION_CHOICE
);
  logic [7:0] tx_term_src;
  logic [7:0] chan_select;
  logic [7:0] count_ctrl;
  logic latch_ch_prev;
  logic latch_all_prev;
  logic [HOLD_W-1:0] clr_ch_hold;
  logic [HOLD_W-1:0] clr_all_hold;

  wire wr_stb = !CS_N && !WR_N;
  wire rd_stb = !CS_N && !RD_N;
  wire hit_src = ADDR == TX_TERM_SRC_OFFSET;
  wire hit_sel = ADDR == CHAN_SELECT_OFFSET;
  wire hit_ctrl = ADDR == COUNT_CTRL_OFFSET;
  wire hit_read = ADDR == COUNT_READ_OFFSET;

  wire tx_enable_source_sel = tx_term_src[TX_ENABLE_SOURCE_SEL_BIT];
  wire rx_termination_source_sel = tx_term_src[RX_TERMINATION_SOURCE_SEL_BIT];
  wire [NUM_CHAN-1:0] next_tx_enable = tx_enable_source_sel ? TX_ENABLE_PIN : TX_ENABLE_REG;
  wire [NUM_CHAN-1:0] next_rx_term =
    rx_termination_source_sel ? {NUM_CHAN{RX_TERM_PIN}} : RX_TERM_REG;

  // Channel code decode: value minus one, codes past the last channel select none
  wire [3:0] chan_code = chan_select[3:0];
  wire chan_valid = (chan_code >= CHAN_CODE_FIRST) && (chan_code <= CHAN_CODE_LAST);
  wire [3:0] chan_off = chan_code - CHAN_CODE_FIRST;
  wire [2:0] chan_idx = chan_off[2:0];

  wire counter_byte_choice = count_ctrl[COUNTER_BYTE_CHOICE_BIT];
  wire per_channel_count_latch = count_ctrl[PER_CHANNEL_COUNT_LATCH_BIT];
  wire per_channel_count_clear = count_ctrl[PER_CHANNEL_COUNT_CLEAR_BIT];
  wire all_count_latch = count_ctrl[ALL_COUNT_LATCH_BIT];
  wire all_count_clear = count_ctrl[ALL_COUNT_CLEAR_BIT];

  // Latch on the rising edge so a bit left at 1 does not keep refreshing
  wire latch_ch = per_channel_count_latch && !latch_ch_prev;
  wire latch_all = all_count_latch && !latch_all_prev;
  // A clear shorter than the hold time is ignored to reject bus glitches
  wire clr_ch = per_channel_count_clear && (clr_ch_hold == CLEAR_HOLD_COUNT);
  wire clr_all = all_count_clear && (clr_all_hold == CLEAR_HOLD_COUNT);

  wire [NUM_CHAN-1:0] chan_hit = chan_valid ? (NUM_CHAN'(1) << chan_idx) : '0;
  logic [COUNT_W-1:0] held_w [NUM_CHAN];

  lgc_chan_if ch [NUM_CHAN] ();

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      assign ch[gi].bump = VIOLATION_PULSE[gi];
      assign ch[gi].latch = (latch_ch && chan_hit[gi]) || latch_all;
      assign ch[gi].clear = (clr_ch && chan_hit[gi]) || clr_all;
      assign held_w[gi] = ch[gi].held;
      lgc_counter u_counter (
        .MCLK(MCLK),
        .RSTN(RSTN),
        .chan(ch[gi])
      );
    end
  endgenerate

  wire [COUNT_W-1:0] sel_held = held_w[chan_idx];
  wire [7:0] count_byte = !chan_valid ? 8'h00 :
                          counter_byte_choice ? sel_held[15:8] : sel_held[7:0];

  wire [7:0] next_rdata = !rd_stb ? 8'h00 :
                          hit_src ? tx_term_src :
                          hit_sel ? chan_select :
                          hit_ctrl ? count_ctrl :
                          hit_read ? count_byte : 8'h00;

  wire [HOLD_W-1:0] next_clr_ch_hold = !per_channel_count_clear ? '0 :
    (clr_ch_hold == CLEAR_HOLD_COUNT) ? clr_ch_hold : clr_ch_hold + 7'h01;
  wire [HOLD_W-1:0] next_clr_all_hold = !all_count_clear ? '0 :
    (clr_all_hold == CLEAR_HOLD_COUNT) ? clr_all_hold : clr_all_hold + 7'h01;

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      tx_term_src <= TX_TERM_SRC_RESET;
      chan_select <= CHAN_SELECT_RESET;
      count_ctrl <= COUNT_CTRL_RESET;
    end else if (wr_stb) begin
      if (hit_src) begin
        tx_term_src <= WDATA;
      end
      if (hit_sel) begin
        chan_select <= WDATA;
      end
      if (hit_ctrl) begin
        count_ctrl <= WDATA;
      end
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      latch_ch_prev <= 1'b0;
      latch_all_prev <= 1'b0;
      clr_ch_hold <= '0;
      clr_all_hold <= '0;
    end else begin
      latch_ch_prev <= per_channel_count_latch;
      latch_all_prev <= all_count_latch;
      clr_ch_hold <= next_clr_ch_hold;
      clr_all_hold <= next_clr_all_hold;
    end
  end

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      RDATA <= 8'h00;
      TRANSMITTER_OUTPUT_ENABLE <= '0;
      RX_TERMINATION_CHOICE <= '0;
    end else begin
      RDATA <= next_rdata;
      TRANSMITTER_OUTPUT_ENABLE <= next_tx_enable;
      RX_TERMINATION_CHOICE <= next_rx_term;
    end
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);

  tx_source_a: assert property (
    TRANSMITTER_OUTPUT_ENABLE ==
      ($past(tx_term_src[7]) ? $past(TX_ENABLE_PIN) : $past(TX_ENABLE_REG)))
    else $error("Transmit enable taken from wrong source");
  rx_source_a: assert property (
    $past(tx_term_src[6]) |-> RX_TERMINATION_CHOICE == {NUM_CHAN{$past(RX_TERM_PIN)}})
    else $error("Termination not following the global pin");
  // Host never strobes twice in a row, so the readback follows one idle cycle
  spare_store_a: assert property (
    wr_stb && hit_src ##1 !wr_stb ##1 rd_stb && hit_src && !wr_stb
      |=> RDATA[5:0] == $past(WDATA[5:0], 3))
    else $error("Spare source bits did not read back");
  upper_store_a: assert property (
    wr_stb && hit_sel |=> chan_select[7:4] == $past(WDATA[7:4]))
    else $error("Upper select bits not stored");
  code_none_a: assert property (
    chan_code == CHAN_CODE_NONE || chan_code > 4'h8 |-> chan_hit == '0)
    else $error("Unused code selected a channel");
  code_map_a: assert property (
    chan_code inside {[4'h1:4'h8]} |-> chan_hit == (8'h01 << (chan_code - 4'h1)))
    else $error("Channel code maps to wrong channel");
  no_chan_read_a: assert property (
    rd_stb && hit_read && !chan_valid |=> RDATA == 8'h00)
    else $error("Readback nonzero with no channel selected");
  byte_read_a: assert property (
    rd_stb && hit_read && chan_valid |=> RDATA == ($past(counter_byte_choice) ?
      $past(sel_held[15:8]) : $past(sel_held[7:0])))
    else $error("Readback returned wrong byte");
  short_clear_a: assert property (
    $rose(per_channel_count_clear) |-> !clr_ch [*8])
    else $error("Short clear reached the counter");

  // Storage, refusal, pulse and clear-hold behaviour of the control registers, and the register-bit termination source
  src_store_a: assert property (
    wr_stb && hit_src |=> tx_term_src == $past(WDATA))
    else $error("Source register did not take the write");
  rx_reg_a: assert property (
    !$past(tx_term_src[6]) |-> RX_TERMINATION_CHOICE == $past(RX_TERM_REG))
    else $error("Termination not following the channel bits");
  sel_store_a: assert property (
    wr_stb && hit_sel |=> chan_select[3:0] == $past(WDATA[3:0]))
    else $error("Channel field not stored");
  sel_read_a: assert property (
    rd_stb && hit_sel |=> RDATA == $past(chan_select))
    else $error("Select register read back wrong");
  ctrl_store_a: assert property (
    wr_stb && hit_ctrl |=> count_ctrl == $past(WDATA))
    else $error("Counter control register not stored");
  read_only_a: assert property (
    wr_stb && hit_read |=> $stable(tx_term_src) && $stable(chan_select) && $stable(count_ctrl))
    else $error("Write to the readback address changed a register");
  idle_read_a: assert property (
    !rd_stb |=> RDATA == 8'h00)
    else $error("Read data not zero outside a read");
  latch_pulse_a: assert property (
    latch_ch |=> !latch_ch)
    else $error("Channel latch lasted more than one cycle");
  all_latch_a: assert property (
    latch_all |=> !latch_all)
    else $error("Global latch lasted more than one cycle");
  all_clear_a: assert property (
    $rose(all_count_clear) |-> !clr_all [*8])
    else $error("Short global clear reached the counters");
  clear_gate_a: assert property (
    clr_ch |-> $past(per_channel_count_clear, 8))
    else $error("Clear reached a counter without being held");
endmodule : lgc_global_ctrl

// ===== tb/lgc_host_model.sv
/* Host register bus model: one strobed access per call.
   Assumes the bench calls acc and owns the run order. */
`timescale 1ns/1ps
module lgc_host_model (
  input wire logic mclk,
  output logic cs_n,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    {cs_n, wr_n, rd_n, addr, wdata} = {3'h7, 16'h0000};
  end
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    {cs_n, wr_n, rd_n, addr, wdata} = {1'b0, !w, w, a, d};
    @(posedge mclk);
    #1;
    // Released lines flip so stale values never pass
    {cs_n, wr_n, rd_n, addr, wdata} = {3'h7, ~a, ~d};
  endtask : acc
endmodule : lgc_host_model

// ===== tb/lgc_global_ctrl_tb_top.sv
/* Self-checking bench for the global control and counter select block.
   Assumes the host model drives the bus and reads answer one cycle later. */
`timescale 1ns/1ps
module lgc_global_ctrl_tb_top;
  import lgc_pkg::*;
  logic MCLK = 1'b0;
  logic RSTN = 1'b0;
  logic cs_n, wr_n, rd_n, rx_pin, rd_q = 1'b0;
  logic [7:0] addr, wdata, rdata, tx_reg, tx_pin, rx_reg, viol, tx_oe, rx_ch, v;
  logic [7:0] exp_q[$];
  logic [7:0] ra[4] = '{8'h82, 8'h8c, 8'h8d, 8'h8e};
  logic [15:0] cnt[8];
  logic [15:0] e;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'hceea;
  always #5 MCLK = ~MCLK;
  lgc_host_model u_host (.mclk(MCLK), .cs_n(cs_n), .wr_n(wr_n), .rd_n(rd_n),
    .addr(addr), .wdata(wdata));
  lgc_global_ctrl u_dut (.MCLK(MCLK), .RSTN(RSTN), .CS_N(cs_n), .WR_N(wr_n), .RD_N(rd_n),
    .ADDR(addr), .WDATA(wdata), .RDATA(rdata), .TX_ENABLE_REG(tx_reg),
    .TX_ENABLE_PIN(tx_pin), .RX_TERM_REG(rx_reg), .RX_TERM_PIN(rx_pin),
    .VIOLATION_PULSE(viol), .TRANSMITTER_OUTPUT_ENABLE(tx_oe), .RX_TERMINATION_CHOICE(rx_ch));
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  task cmp(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_host.acc(1'b1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    u_host.acc(1'b0, a, 8'h00);
  endtask : rd
  task clr(input int n, input logic [7:0] x);
    wr(8'h8c, 8'h01);
    wr(8'h8d, 8'h01);
    repeat (n) @(posedge MCLK);
    wr(8'h8d, 8'h00);
    wr(8'h8d, 8'h02);
    wr(8'h8d, 8'h00);
    rd(8'h8e, x);
  endtask : clr
  // Strobes seen at the coming edge; answer checked just after that same edge
  always @(negedge MCLK) rd_q <= !cs_n && !rd_n;
  always @(posedge MCLK) begin
    #2;
    if (rd_q === 1'b1) cmp(rdata, exp_q.pop_front());
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
  initial begin
    {tx_reg, tx_pin, rx_reg, rx_pin, viol} = 33'h0;
    repeat (20) @(posedge MCLK);
    #1 RSTN = 1'b1;
    // Readback register and unmapped space must ignore writes
    wr(8'h8e, 8'hff);
    wr(8'h90, 8'hff);
    foreach (ra[i]) rd(ra[i], 8'h00);
    rd(8'h90, 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      wr(ra[i], v);
      rd(ra[i], v);
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h82, {m[1:0], 6'h00});
      for (int k = 0; k < 4; k++) begin
        @(posedge MCLK);
        #1;
        {tx_reg, tx_pin, rx_reg, rx_pin} = 25'($random(seed));
        @(posedge MCLK);
        #1;
        cmp(tx_oe, m[1] ? tx_pin : tx_reg);
        cmp(rx_ch, m[0] ? {8{rx_pin}} : rx_reg);
      end
    end
    foreach (cnt[c]) cnt[c] = 16'(1 + c * 40);
    for (int i = 0; i < 300; i++) begin
      @(posedge MCLK);
      #1;
      foreach (cnt[c]) viol[c] = (i < cnt[c]);
    end
    @(posedge MCLK);
    #1 viol = 8'h00;
    for (int code = 0; code < 16; code++) begin
      e = (code >= 1 && code <= 8) ? cnt[code-1] : 16'h0000;
      wr(8'h8c, 8'(code));
      wr(8'h8d, 8'h02);
      wr(8'h8d, 8'h00);
      rd(8'h8e, e[7:0]);
      wr(8'h8d, 8'h04);
      rd(8'h8e, e[15:8]);
    end
    clr(50, cnt[0][7:0]);
    clr(105, 8'h00);
    // Clear all, then latch all; channel 7 still held a nonzero count
    wr(8'h8d, 8'h10);
    repeat (105) @(posedge MCLK);
    wr(8'h8d, 8'h08);
    wr(8'h8d, 8'h00);
    wr(8'h8c, 8'h08);
    rd(8'h8e, 8'h00);
    repeat (3) @(posedge MCLK);
    final_report();
  end
endmodule : lgc_global_ctrl_tb_top
